// ==== logic/tpg_timing_pulse_generator.sv ====
// Timing pulse generator: dividers, ring counter, scalers and time pulse counter
//
// Overview of operation
// R1 - Two quadrature flip-flops divide the clock by four
// R2 - Four phase pulses; first/third, second/fourth coincide
// R3 - Either stop request suppresses first phase pulse
// R4 - Two quadrature square waves from divider flip-flops
// R5 - Second divider stepped by second, third phases
// R6 - Five-stage ring gives five offset phases
// R7 - Ring phase two gated by phases one, five
// R8 - Three strobes of three steps, inhibitable
// R9 - Scaler A: seventeen stages fed by ring
// R10 - Scaler A stages beyond first give pulses
// R11 - Scaler B: sixteen stages after scaler A
// R12 - Read strobe puts scaler B on write lines
// R13 - Two-level gray counter, primary then secondary
// R14 - Exactly one primary bit changes per step
// R15 - Twelve decoded time pulses, wrapping to 0000
// R16 - Bits A and C both high clear C
// R17 - Blocked first phase freezes the counter
// R18 - Stop requests take effect only at time twelve
// R19 - Monitor halt at time twelve raises stop
// R20 - Go, alarm or power fail raise restart stop
// R21 - Chosen twelve-code cycle avoids illegal codes
module tpg_timing_pulse_generator
  import tpg_pkg::*;
(
  input  wire logic                        clk_i,                       // 10 MHz block clock
  input  wire logic                        resetn_i,                    // Synchronous reset, active low
  input  wire logic                        monitor_halt_cmd_i,          // Test set halt command (pin)
  input  wire logic                        monitor_go_cmd_i,            // Test set go command (pin)
  input  wire logic                        alarm_input_i,               // Alarm (pin)
  input  wire logic                        power_fail_i,                // Power failure (pin)
  input  wire logic                        strobe_inhibit_i,            // Strobe stop (pin)
  input  wire logic                        scaler_b_read_strobe_i,      // Processor read of scaler B
  output logic                             phase_pulse_first_o,         // First phase pulse
  output logic                             phase_pulse_second_o,        // Second phase pulse
  output logic                             phase_pulse_third_o,         // Third phase pulse
  output logic                             phase_pulse_fourth_o,        // Fourth phase pulse
  output logic                             quad_square_early_o,         // Early quadrature square
  output logic                             quad_square_late_o,          // Late quadrature square
  output logic                             half_rate_square_b_o,        // Second divider square b
  output logic                             half_rate_square_d_o,        // Second divider square d
  output logic [RING_WIDTH-1:0]            ring_phase_o,                // Ring phases one to five
  output logic                             strobe_zero_o,               // Strobe zero
  output logic                             strobe_one_o,                // Strobe one
  output logic                             strobe_two_o,                // Strobe two
  output logic [SCALER_A_STAGES-1:0]       scaler_a_count_o,            // Scaler A stages
  output logic [SCALER_A_STAGES-1:0]       scaler_a_set_pulse_o,        // Scaler A rising pulses
  output logic [SCALER_A_STAGES-1:0]       scaler_a_clr_pulse_o,        // Scaler A falling pulses
  output logic                             scaler_a_stage_one_out_o,    // Scaler A first stage
  output logic                             scaler_a_last_pulse_a_o,     // Last scaler A stage rising
  output logic                             scaler_a_last_pulse_b_o,     // Last scaler A stage falling
  output logic [SCALER_B_STAGES-1:0]       scaler_b_count_o,            // Scaler B stages
  output logic [SCALER_B_STAGES-1:0]       processor_write_lines_o,     // Write lines
  output logic [TIME_PULSES-1:0]           time_pulse_o,                // Time pulses one to twelve
  output logic [3:0]                       gray_code_o,                 // Secondary level code
  output logic                             stop_request_monitor_o,      // First stop request
  output logic                             stop_request_restart_o,      // Second stop request
  output logic                             global_restart_o             // Global restart
);

  typedef struct packed {
    logic [PIN_COUNT-1:0][SYNC_DEPTH-1:0] sync;                         // Pin synchronisers
    logic [PIN_COUNT-1:0]                 pin;                          // Filtered pin levels
    logic                                 div_early;                    // First divider early FF
    logic                                 div_late;                     // First divider late FF
    logic                                 half_b;                       // Second divider FF b
    logic                                 half_d;                       // Second divider FF d
    logic [RING_WIDTH-1:0]                ring;                         // Ring, bit 0 is phase one
    logic [3:0]                           prim;                         // Primary gray level
    logic [3:0]                           sec;                          // Secondary gray level
    logic                                 pp1;                          // Phase pulses
    logic                                 pp2;
    logic                                 pp3;
    logic                                 pp4;
    logic [2:0]                           strobe;                       // Strobes zero to two
    logic [TIME_PULSES-1:0]               tpulse;                       // Decoded time pulses
    logic                                 stop_mon;                     // First stop request
    logic                                 stop_rst;                     // Second stop request
    logic                                 restart;                      // Global restart
    logic [SCALER_B_STAGES-1:0]           wlines;                       // Write line drive
  } tpg_state_type;

  tpg_state_type               s;                                       // Registered state
  tpg_state_type               next_s;                                  // Next state
  logic                        scaler_tick;                             // Scaler A input step
  logic                        a_carry;                                 // Scaler A to scaler B
  logic [SCALER_A_STAGES-1:0]  a_count;                                 // Scaler A stages
  logic [SCALER_A_STAGES-1:0]  a_set;                                   // Scaler A rising pulses
  logic [SCALER_A_STAGES-1:0]  a_clr;                                   // Scaler A falling pulses
  logic [SCALER_B_STAGES-1:0]  b_count;                                 // Scaler B stages
  logic [PIN_COUNT-1:0]        pins_raw;                                // Raw pin levels

  assign pins_raw = {strobe_inhibit_i, power_fail_i, alarm_input_i, monitor_go_cmd_i, monitor_halt_cmd_i};

  // Scaler A steps once per ring cycle, on the step where phases three and four are high
  // and phases five and one still low
  assign scaler_tick = s.pp3 & s.ring[2] & s.ring[3] & ~s.ring[4] & ~s.ring[0]; // R9

  // Next state of the block outside the two scalers
  always_comb begin
    next_s = s;

    // Pins: three flops; the filtered level follows once flops two and three agree
    for (int p = 0; p < PIN_COUNT; p++) begin
      next_s.sync[p] = {s.sync[p][1:0], pins_raw[p]};
      if (s.sync[p][1] == s.sync[p][2]) begin
        next_s.pin[p] = s.sync[p][2];
      end
    end

    // First divider: early flop steps when both flops agree, late when they differ
    if (s.div_early == s.div_late) begin
      next_s.div_early = ~s.div_early;                                  // R1
    end else begin
      next_s.div_late = s.div_late;
      next_s.div_late = ~s.div_late;                                    // R1
    end

    // Stop requests sampled only while time twelve stands; held while the
    // command stays, so the counter parks on time twelve
    // Never on the edge where the first phase moves the code off time twelve,
    // else the counter would park on time one
    next_s.stop_mon = s.pin[PIN_HALT] & ((s.tpulse[TIME_PULSES-1] & ~s.pp1) | s.stop_mon); // R18 R19
    next_s.stop_rst = (s.pin[PIN_GO] | s.pin[PIN_ALARM] | s.pin[PIN_PFAIL])
                      & ((s.tpulse[TIME_PULSES-1] & ~s.pp1) | s.stop_rst); // R18 R20
    next_s.restart  = s.stop_rst;                                       // R20

    // Phase pulses, one quarter wide; the next stop value gates the first so
    // the secondary level cannot load after the stop is seen
    next_s.pp1 = ~next_s.div_early & next_s.div_late
                 & ~next_s.stop_mon & ~next_s.stop_rst;                 // R2 R3
    next_s.pp3 = ~next_s.div_early & next_s.div_late;                   // R2
    next_s.pp2 = next_s.div_early & ~next_s.div_late;                   // R2
    next_s.pp4 = next_s.div_early & ~next_s.div_late;                   // R2

    // Second divider: same quadrature scheme, stepped by third and second phases
    if (s.pp3) begin
      next_s.half_b = ~s.half_b;                                        // R5
    end
    if (s.pp2) begin
      next_s.half_d = ~s.half_d;                                        // R5
    end

    // Ring steps with square b; phase two is the self-correcting head
    if (s.pp3) begin
      next_s.ring[4:2] = s.ring[3:1];                                   // R6
      next_s.ring[0]   = s.ring[4];                                     // R6
      if (!s.ring[0] && !s.ring[4]) begin
        next_s.ring[1] = 1'b1;                                          // R7
      end else if (s.ring[0] && s.ring[4]) begin
        next_s.ring[1] = 1'b0;                                          // R7
      end
    end

    // Strobes are overlaps of two ring phases two steps apart: three steps wide
    if (s.pin[PIN_SINH]) begin
      next_s.strobe = 3'h0;                                             // R8
    end else begin
      next_s.strobe[0] = next_s.ring[1] & next_s.ring[3];               // R8
      next_s.strobe[1] = next_s.ring[2] & next_s.ring[4];               // R8
      next_s.strobe[2] = next_s.ring[3] & next_s.ring[0];               // R8
    end

    // Primary level: on the second phase set or clear only the bit the step
    // moves; a set or clear, not a toggle, so a repeat while stopped holds
    if (s.pp2) begin
      for (int k = 0; k < TIME_PULSES; k++) begin
        if (s.tpulse[k]) begin
          next_s.prim = (s.prim & ~(GRAY_SEQ[k] ^ GRAY_SEQ[(k + 1) % TIME_PULSES]))
                        | (GRAY_SEQ[(k + 1) % TIME_PULSES] & ~GRAY_SEQ[k]); // R13 R14 R17 R21
        end
      end
    end

    // Secondary level: stores the primary on the first phase; blocked when stopped
    if (s.pp1) begin
      next_s.sec = s.prim;                                              // R13 R17
    end

    // Illegal codes all have A and C high; clearing C lands on a legal code
    if (s.sec[GRAY_A] && s.sec[GRAY_C]) begin
      next_s.sec[GRAY_C]  = 1'b0;                                       // R16
      next_s.prim[GRAY_C] = 1'b0;                                       // R16
    end

    // Decoder: one time pulse per stored code, wrap after twelve
    for (int k = 0; k < TIME_PULSES; k++) begin
      next_s.tpulse[k] = (next_s.sec == GRAY_SEQ[k]);                   // R15
    end

    // Write lines carry scaler B only in the cycle after the read strobe
    next_s.wlines = scaler_b_read_strobe_i ? b_count : '0;             // R12

    if (!resetn_i) begin
      next_s        = '0;
      next_s.ring   = RING_RESET;
      next_s.prim   = GRAY_RESET;
      next_s.sec    = GRAY_RESET;
      next_s.tpulse = '0;
      next_s.tpulse[0] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  // Scaler A: seventeen stages from the ring
  tpg_scaler #(
    .STAGES (SCALER_A_STAGES)
  ) u_scaler_a (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .tick_i      (scaler_tick),
    .count_o     (a_count),
    .set_pulse_o (a_set),
    .clr_pulse_o (a_clr),
    .carry_o     (a_carry)
  );

  // Scaler B: sixteen stages fed by the last scaler A stage
  tpg_scaler #(
    .STAGES (SCALER_B_STAGES)
  ) u_scaler_b (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .tick_i      (a_carry),                                             // R11
    .count_o     (b_count),
    .set_pulse_o (),
    .clr_pulse_o (),
    .carry_o     ()
  );

  // Outputs, all straight from flip-flops
  assign phase_pulse_first_o      = s.pp1;
  assign phase_pulse_second_o     = s.pp2;
  assign phase_pulse_third_o      = s.pp3;
  assign phase_pulse_fourth_o     = s.pp4;
  assign quad_square_early_o      = s.div_early;                        // R4
  assign quad_square_late_o       = s.div_late;                         // R4
  assign half_rate_square_b_o     = s.half_b;
  assign half_rate_square_d_o     = s.half_d;
  assign ring_phase_o             = s.ring;
  assign strobe_zero_o            = s.strobe[0];
  assign strobe_one_o             = s.strobe[1];
  assign strobe_two_o             = s.strobe[2];
  assign scaler_a_count_o         = a_count;
  assign scaler_a_set_pulse_o     = a_set;
  assign scaler_a_clr_pulse_o     = a_clr;
  assign scaler_a_stage_one_out_o = a_count[0];                         // R10
  assign scaler_a_last_pulse_a_o  = a_set[SCALER_A_STAGES-1];
  assign scaler_a_last_pulse_b_o  = a_clr[SCALER_A_STAGES-1];
  assign scaler_b_count_o         = b_count;
  assign processor_write_lines_o  = s.wlines;
  assign time_pulse_o             = s.tpulse;
  assign gray_code_o              = s.sec;
  assign stop_request_monitor_o   = s.stop_mon;
  assign stop_request_restart_o   = s.stop_rst;
  assign global_restart_o         = s.restart;

  // Checks
  quad_phase_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R1
    (s.div_early != $past(s.div_early)) |-> (s.div_late == $past(s.div_late)))
    else $error("both divider flops changed together");

  phase_pair_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R2
    (s.pp1 |-> s.pp3) and (s.pp2 |-> s.pp4 ##2 s.pp3))
    else $error("phase pulses out of step");

  stop_block_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R3
    (s.stop_mon || s.stop_rst) |-> !s.pp1)
    else $error("first phase pulse while stopped");

  half_rate_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5
    s.pp3 |=> (s.half_b != $past(s.half_b)))
    else $error("square b did not toggle");

  ring_head_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R7
    (s.pp3 && s.ring == 5'h00) |=> (s.ring == 5'h02))
    else $error("ring did not start phase two");

  strobe_inh_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R8
    s.pin[PIN_SINH] |=> (s.strobe == 3'h0))
    else $error("strobe while inhibited");

  gray_step_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R14
    ($past(resetn_i) && (s.sec != $past(s.sec))) |-> $onehot(s.sec ^ $past(s.sec)))
    else $error("gray counter changed more than one bit");

  halt_place_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R18
    s.stop_mon |-> s.tpulse[TIME_PULSES-1])
    else $error("monitor stop outside time twelve");

  restart_cause_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R20
    $rose(s.stop_rst) |-> ($past(s.tpulse[TIME_PULSES-1]) ##1 s.restart))
    else $error("restart stop without time twelve");

  wline_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R12
    scaler_b_read_strobe_i |=> (s.wlines == $past(b_count)))
    else $error("write lines do not carry scaler B");

  freeze_sec_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R17
    ($past(s.stop_mon || s.stop_rst) && (s.stop_mon || s.stop_rst)) |-> $stable(s.sec))
    else $error("gray counter moved while stopped");

endmodule : tpg_timing_pulse_generator

// ==== logic/tpg_pkg.sv ====
// Constants of the timing pulse generator
package tpg_pkg;

  localparam int unsigned RING_WIDTH      = 5;                  // Ring counter flip-flops
  localparam int unsigned SCALER_A_STAGES = 17;                 // Scaler A divide-by-two stages
  localparam int unsigned SCALER_B_STAGES = 16;                 // Scaler B divide-by-two stages
  localparam int unsigned TIME_PULSES     = 12;                 // Time pulses per count cycle
  localparam int unsigned SYNC_DEPTH      = 3;                  // Pin synchroniser depth
  localparam int unsigned PIN_COUNT       = 5;                  // Synchronised pin inputs
  localparam int unsigned CLK_HZ          = 10_000_000;         // Block clock rate
  localparam int unsigned QUARTERS        = 4;                  // Clock cycles per first-divider period

  // Pin slots in the synchroniser bank
  localparam int unsigned PIN_HALT   = 0;                       // Monitor halt command
  localparam int unsigned PIN_GO     = 1;                       // Monitor go command
  localparam int unsigned PIN_ALARM  = 2;                       // Alarm input
  localparam int unsigned PIN_PFAIL  = 3;                       // Power failure input
  localparam int unsigned PIN_SINH   = 4;                       // Strobe inhibit input

  // Gray counter bit positions: A is the top bit, D the bottom
  localparam int unsigned GRAY_A = 3;                           // Bit A
  localparam int unsigned GRAY_C = 1;                           // Bit C

  // Reset values
  localparam logic [3:0]            GRAY_RESET = 4'h0;          // Counter starts at 0000
  localparam logic [RING_WIDTH-1:0] RING_RESET = 5'h00;         // Ring starts all low

  // Twelve-step single-bit-change cycle, entry k is the code of time pulse k+1
  localparam logic [TIME_PULSES-1:0][3:0] GRAY_SEQ = {
    4'h8, 4'hC, 4'hD, 4'h9, 4'h1, 4'h5,
    4'h4, 4'h6, 4'h7, 4'h3, 4'h2, 4'h0
  };

endpackage : tpg_pkg

// ==== logic/tpg_scaler.sv ====
// Cascaded divide-by-two scaler with decoded pulses on every stage but the first
module tpg_scaler
  import tpg_pkg::*;
#(
  parameter int unsigned STAGES = 17                            // Number of stages
) (
  input  wire logic              clk_i,                         // Block clock
  input  wire logic              resetn_i,                      // Synchronous reset, active low
  input  wire logic              tick_i,                        // One-cycle input step
  output logic [STAGES-1:0]      count_o,                       // Stage flip-flops
  output logic [STAGES-1:0]      set_pulse_o,                   // Stage went high (stage 1 silent)
  output logic [STAGES-1:0]      clr_pulse_o,                   // Stage went low (stage 1 silent)
  output logic                   carry_o                        // Last stage wrapped to low
);

  typedef struct packed {
    logic [STAGES-1:0] count;                                   // Divider stages
    logic [STAGES-1:0] set_pulse;                               // Rising decodes
    logic [STAGES-1:0] clr_pulse;                               // Falling decodes
    logic              carry;                                   // Output to the next scaler
  } tpg_scaler_state_type;

  tpg_scaler_state_type s;                                      // Registered state
  tpg_scaler_state_type next_s;                                 // Next state
  logic [STAGES-1:0]    toggle;                                 // Stage toggle enables

  // On an input step, each stage toggles when every stage below it is high
  genvar k;
  generate
    for (k = 0; k < STAGES; k++) begin : g_stage
      if (k == 0) begin : g_first
        assign toggle[k] = tick_i;
      end else begin : g_rest
        assign toggle[k] = toggle[k-1] & s.count[k-1];
      end
    end
  endgenerate

  // Next state; synchronous ripple avoids the skew of a real ripple chain
  always_comb begin
    next_s           = s;
    next_s.count     = s.count ^ toggle;                        // R9 R11
    next_s.set_pulse = toggle & ~s.count;                       // R10
    next_s.clr_pulse = toggle & s.count;                        // R10
    next_s.set_pulse[0] = 1'b0;                                 // R10
    next_s.clr_pulse[0] = 1'b0;                                 // R10
    next_s.carry     = toggle[STAGES-1] & s.count[STAGES-1];
    if (!resetn_i) begin
      next_s = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign count_o     = s.count;
  assign set_pulse_o = s.set_pulse;
  assign clr_pulse_o = s.clr_pulse;
  assign carry_o     = s.carry;

  wrap_carry_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // R9
    (tick_i && (&s.count)) |=> (s.count == '0) && s.carry)
    else $error("scaler did not wrap with carry");

endmodule : tpg_scaler

// ==== tb/tpg_cpu_model.sv ====
// Processor side model: reads scaler B at random moments
module tpg_cpu_model (
  input  wire logic clk_i,   // Block clock
  input  wire logic en_i,    // Reads allowed
  output logic      read_o   // Scaler B read strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial read_o = 1'b0;
  // Random reads, moved off the sampling edge so the design sees a settled level
  always @(negedge clk_i) begin
    read_o <= en_i && ($urandom % 3 == 0);
  end
endmodule : tpg_cpu_model

// ==== tb/tpg_timing_pulse_generator_tb.sv ====
// Self-checking bench of the timing pulse generator
module tpg_timing_pulse_generator_tb import tpg_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, resetn = 1'b0, rd, sinh = 1'b0, psinh = 1'b0, run = 1'b0;
  logic [3:0] cmd = 4'h0;                             // Halt, go, alarm, power fail
  logic pp1, pp2, pp3, pp4, qe, ql, pqe = 0, pql = 0, sb0, sb1, sb2;
  logic hb, hd, s1, la, lb, phb = 1'b0, phd = 1'b0, ppp2 = 1'b0, ppp3 = 1'b0; // Second divider, scaler taps
  logic [SCALER_A_STAGES-1:0] psca = '0;               // Scaler A one sample back
  logic smon, srst, grst, psmon = 0, psrst = 0, pstop = 0;
  logic [RING_WIDTH-1:0]      ring;
  logic [RING_WIDTH-1:0]      hist [40];             // Ring history, one period deep
  logic [SCALER_A_STAGES-1:0] sca, sca_sav, sset, sclr;
  logic [SCALER_B_STAGES-1:0] scb, wl;
  logic [TIME_PULSES-1:0]     tp;
  logic [3:0]                 gray, pg = 4'h0;
  int fail_count = 0, cmp_count = 0, cyc = 0, steps = 0, nsb = 0, age = 0;

  tpg_cpu_model u_tpg_cpu_model (.clk_i(clk), .en_i(run), .read_o(rd));
  tpg_timing_pulse_generator u_tpg_timing_pulse_generator (.clk_i(clk), .resetn_i(resetn),
    .monitor_halt_cmd_i(cmd[0]), .monitor_go_cmd_i(cmd[1]), .alarm_input_i(cmd[2]),
    .power_fail_i(cmd[3]), .strobe_inhibit_i(sinh), .scaler_b_read_strobe_i(rd),
    .phase_pulse_first_o(pp1), .phase_pulse_second_o(pp2), .phase_pulse_third_o(pp3),
    .phase_pulse_fourth_o(pp4), .quad_square_early_o(qe), .quad_square_late_o(ql),
    .half_rate_square_b_o(hb), .half_rate_square_d_o(hd), .ring_phase_o(ring), .strobe_zero_o(sb0),
    .strobe_one_o(sb1), .strobe_two_o(sb2), .scaler_a_count_o(sca), .scaler_a_set_pulse_o(sset),
    .scaler_a_clr_pulse_o(sclr), .scaler_a_stage_one_out_o(s1), .scaler_a_last_pulse_a_o(la),
    .scaler_a_last_pulse_b_o(lb), .scaler_b_count_o(scb), .processor_write_lines_o(wl),
    .time_pulse_o(tp), .gray_code_o(gray), .stop_request_monitor_o(smon),
    .stop_request_restart_o(srst), .global_restart_o(grst));

  always #50 clk = ~clk;

  // Single comparison point
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // Monitor on the falling edge, where outputs are settled
  always @(negedge clk) begin
    if (run) begin
      if (!(smon | srst | pstop)) check("pp3", pp3, pp1);
      check("pp4", pp4, pp2);
      check("pp1 and pp2", pp1 & pp2, 1'b0);
      check("quad edges", (qe ^ pqe) & (ql ^ pql), 1'b0);
      if (pstop && (smon | srst)) check("pp1 stopped", pp1, 1'b0);
      if (pstop && (smon | srst)) check("gray frozen", gray, pg);
      if ((smon & ~psmon) | (srst & ~psrst)) check("stop time", tp[11], 1'b1);
      check("restart", grst, psrst);
      check("write lines", wl, rd ? scb : '0);
      check("stage one pulses", {sset[0], sclr[0]}, 2'b00);
      check("stage one out", s1, sca[0]);
      check("last pulses", {la, lb}, {sset[SCALER_A_STAGES-1], sclr[SCALER_A_STAGES-1]});
      check("set pulses", sset, sca & ~psca & ~17'h00001);
      check("clear pulses", sclr, ~sca & psca & ~17'h00001);
      check("square b", hb ^ phb, ppp3);
      check("square d", hd ^ phd, ppp2);
      check("one hot", $onehot(tp), 1'b1);
      // Illegal codes are those with A and C both high
      check("legal code", gray[GRAY_A] & gray[GRAY_C], 1'b0);
      if (gray !== pg) begin
        check("gray step", $countones(gray ^ pg), 1);
        steps++;
        if (gray == 4'h0) begin
          check("cycle length", steps, TIME_PULSES);
          steps = 0;
        end
      end
      if (cyc >= 40) check("ring period", ring, hist[cyc % 40]);
      hist[cyc % 40] = ring;
      nsb += sb0 + sb1 + sb2;
      age = (sinh !== psinh) ? 0 : age + 1;
      if (cyc % 40 == 39) begin
        // Only windows with a long-settled inhibit level are judged
        if (age >= 48) check("strobe time", nsb, sinh ? 0 : 36);
        if (cyc > 39) check("scaler a step", sca - sca_sav, 1);
        sca_sav = sca;
        nsb = 0;
      end
      {pg, pqe, pql, pstop, psmon, psrst, psinh} = {gray, qe, ql, smon | srst, smon, srst, sinh};
      {phb, phd, ppp2, ppp3, psca} = {hb, hd, pp2, pp3, sca};
      cyc++;
    end
  end

  // Main sequence: reset, random inhibit spans, then each stop cause in turn
  initial begin
    int w;
    void'($urandom(32'h7f461eec));
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("reset tp", tp, 12'h001);
    check("reset gray", gray, 4'h0);
    resetn = 1'b1;
    run = 1'b1;
    repeat (6) begin
      sinh <= 1'($urandom % 2);
      repeat (150 + $urandom % 100) @(negedge clk);
    end
    sinh <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      repeat ($urandom % 50) @(negedge clk);
      cmd[k] <= 1'b1;
      w = 0;
      while (!(smon | srst) && w < 200) begin
        @(negedge clk);
        w++;
      end
      check("stop raised", k == 0 ? smon : srst, 1'b1);
      repeat (60) @(negedge clk);
      cmd[k] <= 1'b0;
      repeat (20) @(negedge clk);
      check("stop cleared", smon | srst, 1'b0);
    end
    give_verdict();
  end

  // Watchdog, far beyond the expected few thousand cycles
  initial begin
    #(20000 * 100);
    fail_count++;
    give_verdict();
  end
endmodule : tpg_timing_pulse_generator_tb
